/* ctm_clk_sel.v */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.vh"
// Turns the selected timer clock source into a one-cycle count enable.
module ctm_clk_sel (
   input  wire       sys_clk,
   input  wire       reset_n,
   input  wire [2:0] clk_sel,
   input  wire       fh_tick,
   input  wire       ftbc_tick,
   input  wire       ext_clk,
   output reg        tick_q
);
   reg  [1:0] sys_div_q;
   reg  [5:0] h_div_q;
   reg        ext_prev_q;
   reg        tick_d;

   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_div_q  <= 2'h0;
         h_div_q    <= 6'h00;
         ext_prev_q <= 1'b0;
         tick_q     <= 1'b0;
      end else begin
         sys_div_q  <= sys_div_q + 2'h1;
         if (fh_tick) begin
            h_div_q <= h_div_q + 6'h01;
         end
         ext_prev_q <= ext_clk;
         tick_q     <= tick_d;
      end
   end

   always @* begin
      case (clk_sel)
         `CTM_CK_SYS_DIV4: tick_d = (sys_div_q == 2'h3);
         `CTM_CK_SYS:      tick_d = 1'b1;
         `CTM_CK_H_DIV16:  tick_d = fh_tick && (h_div_q[3:0] == 4'hf);
         `CTM_CK_H_DIV64:  tick_d = fh_tick && (h_div_q == 6'h3f);
         `CTM_CK_TBC:      tick_d = ftbc_tick;
         `CTM_CK_EXT_RISE: tick_d = ext_clk && !ext_prev_q;  // see R19
         `CTM_CK_EXT_FALL: tick_d = !ext_clk && ext_prev_q;  // see R19
         default:          tick_d = 1'b0;                    // see R18
      endcase
   end
endmodule // ctm_clk_sel
`default_nettype wire

/* ctm_core.v */
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.vh"
//Contract
// R1: A 10-bit up-counter advanced by a selectable internal or external clock.
// R2: Period match compares three period bits with the counter's top three bits.
// R3: Compare-A match compares all ten bits with the counter.
// R4: Software only clears the counter, by taking the on bit from 0 to 1.
// R5: Counter clears on overflow or selected compare match, raising an event; the code skips the compare-match clear in PWM mode.
// R6: Three modes: compare-match output, timer/event counter, PWM output.
// R7: Drives one or two output pins, same signal or its inverse.
// R8: Six timer registers: counter pair, compare-A pair, two controls.
// R9: Control field positions are fixed as laid out in the two control registers.
// R10: Counter low byte gives bits 7..0, high byte bits 9..8 in 1..0.
// R11: Compare-A bytes hold bits 7..0 and 9..8, read/write, reset zero.
// R12: Unimplemented bits of routing, counter-high and compare-high read zero.
// R13: Low bytes are reached only through one shared 8-bit holding buffer.
// R14: Low write fills buffer; high write stores high and moves buffer to low.
// R15: High read returns high directly and latches low byte into buffer.
// R16: Software writes low then high, reads high then low.
// R17: A routing bit at one connects the timer function to the shared pin.
// R18: Clock select code 101 disconnects the clock; counter holds.
// R19: External clock counts on rising or falling edge as selected.
// R20: On and not paused, count up one per active edge, wrap after 1023.
module ctm_core (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        fh_tick,
   input  wire        ftbc_tick,
   input  wire        timer_ext_clock_pin,
   output reg         timer_output_pin_0,
   output reg         timer_output_pin_1,
   output reg  [7:0]  pin_route_ctl_a,
   output reg  [7:0]  pin_route_ctl_b,
   output reg         period_match_q,
   output reg         compare_a_match_q
);
   localparam MODE_CMP   = 2'h0;
   localparam MODE_CAP   = 2'h1;
   localparam MODE_PWM   = 2'h2;
   localparam MODE_TIMER = 2'h3;

   reg  [7:0] ctl0_q;
   reg  [7:0] ctl1_q;
   reg  [9:0] count_q;
   reg  [9:0] cmp_a_q;
   reg  [7:0] hold_buf_q;
   reg        on_prev_q;
   reg        out_q;
   wire       tick;
   wire       wr_en;
   wire       rd_en;
   wire [2:0] period_bits;
   wire [1:0] timer_mode_select;
   wire       p_hit;
   wire       a_hit;
   wire       clear_hit;
   reg        pwm_d;
   reg  [31:0] rdata_d;
   reg        err_d;

   // Byte lanes of a register word above bit 7 always read as zero.
   function [31:0] ctm_byte;
      input [7:0] b;
      begin
         ctm_byte = {24'h000000, b};
      end
   endfunction

   function ctm_mapped;
      input [11:0] a;
      begin
         ctm_mapped = (a[11:5] == 7'h00) && (a[1:0] == 2'h0);          // see R8
      end
   endfunction

   assign period_bits       = ctl0_q[`CTM_C0_PER_HI:`CTM_C0_PER_LO];          // see R9
   assign timer_mode_select = ctl1_q[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];        // see R9
   assign wr_en = psel && penable && pwrite && ctm_mapped(paddr);
   assign rd_en = psel && penable && !pwrite && ctm_mapped(paddr);

   // Period zero matches whenever the top three counter bits are zero.
   assign p_hit = tick && (count_q[9:7] == period_bits);                       // see R2
   assign a_hit = tick && (count_q == cmp_a_q);                                // see R3
   assign clear_hit = ctl1_q[`CTM_C1_CCLR] ? a_hit : p_hit;                    // see R5

   ctm_clk_sel u_clk_sel (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .clk_sel   (ctl0_q[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO]),
      .fh_tick   (fh_tick),
      .ftbc_tick (ftbc_tick),
      .ext_clk   (timer_ext_clock_pin),
      .tick_q    (tick)
   );

   // Counter: cleared by the on bit's rising edge, else counts while running.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q   <= 10'h000;
         on_prev_q <= 1'b0;
      end else begin
         on_prev_q <= ctl0_q[`CTM_C0_ON];
         if (ctl0_q[`CTM_C0_ON] && !on_prev_q) begin
            count_q <= 10'h000;                                                // see R4
         end else if (ctl0_q[`CTM_C0_ON] && !ctl0_q[`CTM_C0_PAUSE] && tick) begin
            if (clear_hit && (timer_mode_select != MODE_PWM)) begin
               count_q <= 10'h000;                                             // see R5
            end else if (count_q == `CTM_CNT_MAX) begin
               count_q <= 10'h000;                                             // see R20
            end else begin
               count_q <= count_q + 10'h001;                                   // see R1
            end
         end
      end
   end

   // PWM: period is the full 1024-count wrap, duty from compare A, polarity by control bit.
   always @* begin
      pwm_d = (count_q < cmp_a_q);
   end

   // Output stage; the mode encodings are kept simple since only the core is built.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q              <= 1'b0;
         period_match_q     <= 1'b0;
         compare_a_match_q  <= 1'b0;
         timer_output_pin_0 <= 1'b0;
         timer_output_pin_1 <= 1'b0;
      end else begin
         period_match_q    <= ctl0_q[`CTM_C0_ON] && !ctl0_q[`CTM_C0_PAUSE] && p_hit;   // see R5
         compare_a_match_q <= ctl0_q[`CTM_C0_ON] && !ctl0_q[`CTM_C0_PAUSE] && a_hit;   // see R5
         if (!ctl0_q[`CTM_C0_ON]) begin
            out_q <= ctl1_q[`CTM_C1_OC];
         end else begin
            case (timer_mode_select)                                           // see R6
               MODE_CMP: begin
                  if (a_hit && !ctl0_q[`CTM_C0_PAUSE]) begin
                     out_q <= ~out_q;
                  end
               end
               MODE_PWM: begin
                  out_q <= pwm_d ~^ ctl1_q[`CTM_C1_OC];
               end
               default: begin
                  out_q <= ctl1_q[`CTM_C1_OC];
               end
            endcase
         end
         // The second pin carries the same or inverted signal.
         timer_output_pin_0 <= (out_q ^ ctl1_q[`CTM_C1_POL]) & pin_route_ctl_a[0];                    // see R7
         timer_output_pin_1 <= (out_q ^ ctl1_q[`CTM_C1_POL] ^ ctl1_q[`CTM_C1_DPX]) & pin_route_ctl_a[1]; // see R17
      end
   end

   // Register writes; the compare low byte is only reached via the buffer.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl0_q          <= `CTM_RST_CTL;
         ctl1_q          <= `CTM_RST_CTL;
         cmp_a_q         <= 10'h000;                                           // see R11
         hold_buf_q      <= 8'h00;
         pin_route_ctl_a <= `CTM_RST_ROUTE_A;
         pin_route_ctl_b <= `CTM_RST_ROUTE_B;
      end else begin
         if (wr_en) begin
            case (paddr)
               `CTM_ADDR_CTL0:    ctl0_q <= pwdata[7:0];
               `CTM_ADDR_CTL1:    ctl1_q <= pwdata[7:0];
               `CTM_ADDR_CMPA_LO: hold_buf_q <= pwdata[7:0];                   // see R14
               `CTM_ADDR_CMPA_HI: cmp_a_q <= {pwdata[1:0], hold_buf_q};        // see R14
               `CTM_ADDR_ROUTE_A: pin_route_ctl_a <= pwdata[7:0] & `CTM_ROUTE_A_MASK; // see R17
               `CTM_ADDR_ROUTE_B: pin_route_ctl_b <= pwdata[7:0] & `CTM_ROUTE_B_MASK; // see R17
               default: begin
               end
            endcase
         end else if (rd_en) begin
            // Misordered accesses simply see whatever the shared buffer holds.
            case (paddr)
               `CTM_ADDR_CNT_HI:  hold_buf_q <= count_q[7:0];                  // see R15
               `CTM_ADDR_CMPA_HI: hold_buf_q <= cmp_a_q[7:0];                  // see R15
               default: begin
               end
            endcase
         end
      end
   end

   always @* begin
      err_d = 1'b0;
      case (paddr)
         `CTM_ADDR_CTL0:    rdata_d = ctm_byte(ctl0_q);
         `CTM_ADDR_CTL1:    rdata_d = ctm_byte(ctl1_q);
         `CTM_ADDR_CNT_LO:  rdata_d = ctm_byte(hold_buf_q);                    // see R13
         `CTM_ADDR_CNT_HI:  rdata_d = ctm_byte({6'h00, count_q[9:8]});         // see R10
         `CTM_ADDR_CMPA_LO: rdata_d = ctm_byte(hold_buf_q);                    // see R13
         `CTM_ADDR_CMPA_HI: rdata_d = ctm_byte({6'h00, cmp_a_q[9:8]});         // see R12
         `CTM_ADDR_ROUTE_A: rdata_d = ctm_byte(pin_route_ctl_a);
         `CTM_ADDR_ROUTE_B: rdata_d = ctm_byte(pin_route_ctl_b);
         default: begin
            rdata_d = 32'h00000000;
            err_d   = 1'b1;
         end
      endcase
   end

   // No wait state: pready rises in the second access cycle.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && err_d;
         prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h00000000;
      end
   end
endmodule // ctm_core
`default_nettype wire

/* ctm_core_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module ctm_core_chk (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timer_output_pin_0,
   input wire logic [7:0]  pin_route_ctl_a,
   input wire logic [7:0]  pin_route_ctl_b
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   wire setup = psel && !penable;
   wire done  = psel && penable && pready;
   a_ready_after_setup: assert property (setup |=> pready) else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready) else $error("ready held");
   a_unmapped_err: assert property (setup && paddr >= 12'h020 |=> pslverr) else $error("no error");
   a_mapped_ok: assert property (setup && paddr < 12'h020 && paddr[1:0] == 2'b00 |=> !pslverr)
      else $error("error on mapped address");
   a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
   a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0) else $error("refused read data");
   a_high_bytes_zero: assert property (pready && !pwrite && (paddr == 12'h00c || paddr == 12'h014)
      |-> prdata[31:2] == 30'h0) else $error("high byte upper bits set");
   a_route_masks: assert property ((pin_route_ctl_a & 8'h0c) == 8'h00 && (pin_route_ctl_b & 8'hcc) == 8'h00)
      else $error("unimplemented routing bit set");
   a_route_write: assert property (done && pwrite && paddr == 12'h018
      |=> pin_route_ctl_a == ($past(pwdata[7:0]) & 8'hf3)) else $error("routing write lost");
   a_pin_gated: assert property (!pin_route_ctl_a[0] && !$past(pin_route_ctl_a[0]) |-> !timer_output_pin_0)
      else $error("output on unrouted pin");
endmodule // ctm_core_chk
bind ctm_core ctm_core_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_output_pin_0(timer_output_pin_0), .pin_route_ctl_a(pin_route_ctl_a),
   .pin_route_ctl_b(pin_route_ctl_b));
`default_nettype wire

/* ctm_defs.vh */
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH
// Register byte addresses, one aligned 32-bit word each.
`define CTM_ADDR_CTL0      12'h000
`define CTM_ADDR_CTL1      12'h004
`define CTM_ADDR_CNT_LO    12'h008
`define CTM_ADDR_CNT_HI    12'h00c
`define CTM_ADDR_CMPA_LO   12'h010
`define CTM_ADDR_CMPA_HI   12'h014
`define CTM_ADDR_ROUTE_A   12'h018
`define CTM_ADDR_ROUTE_B   12'h01c
// Control register 0 fields.
`define CTM_C0_PAUSE       7
`define CTM_C0_CKSEL_HI    6
`define CTM_C0_CKSEL_LO    4
`define CTM_C0_ON          3
`define CTM_C0_PER_HI      2
`define CTM_C0_PER_LO      0
// Control register 1 fields.
`define CTM_C1_MODE_HI     7
`define CTM_C1_MODE_LO     6
`define CTM_C1_PINF_HI     5
`define CTM_C1_PINF_LO     4
`define CTM_C1_OC          3
`define CTM_C1_POL         2
`define CTM_C1_DPX         1
`define CTM_C1_CCLR        0
// Clock select codes.
`define CTM_CK_SYS_DIV4    3'h0
`define CTM_CK_SYS         3'h1
`define CTM_CK_H_DIV16     3'h2
`define CTM_CK_H_DIV64     3'h3
`define CTM_CK_TBC         3'h4
`define CTM_CK_RESERVED    3'h5
`define CTM_CK_EXT_RISE    3'h6
`define CTM_CK_EXT_FALL    3'h7
// Reset values, routing write masks and counter maximum.
`define CTM_RST_CTL        8'h00
`define CTM_RST_ROUTE_A    8'hb3
`define CTM_RST_ROUTE_B    8'h33
`define CTM_ROUTE_A_MASK   8'hf3
`define CTM_ROUTE_B_MASK   8'h33
`define CTM_CNT_MAX        10'h3ff
`endif

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctm_defs.vh"
module testbench;
   logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, ext, ftbc, err, p0, p1, pm, am;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v, seed;
   logic [7:0]  ra, rb;
   int          error_cnt, cmp_count, n, cm;
   ctm_core DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fh_tick(1'b1),
      .ftbc_tick(ftbc), .timer_ext_clock_pin(ext), .timer_output_pin_0(p0), .timer_output_pin_1(p1),
      .pin_route_ctl_a(ra), .pin_route_ctl_b(rb), .period_match_q(pm), .compare_a_match_q(am));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) ftbc <= seed[3];
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic summarize();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Ready, read data and error are taken at the rising edge that completes the access.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         chk(0, 1);
         summarize();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // High byte first, so the low byte read comes from the snapshot taken with it.
   task automatic cnt(input int e);
      rdc(`CTM_ADDR_CNT_HI, e >> 8);
      rdc(`CTM_ADDR_CNT_LO, e & 255);
   endtask
   task automatic gap(input logic sel, input int e);
      int c;
      c = 0;
      n = 0;
      while (n < 2 && c < 3000) begin
         @(negedge sys_clk);
         c++;
         if ((sel ? pm : am) === 1'b1) begin
            n++;
            if (n == 1) c = 0;
         end
      end
      chk(c, e);
      if (c == 3000) summarize();
   endtask
   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge sys_clk);
         ext <= 1'b1;
         repeat (3) @(posedge sys_clk);
         ext <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      repeat (8) @(posedge sys_clk);
   endtask
   initial begin
      seed = 32'hc01ba7d6;
      {reset_n, psel, penable, pwrite, ext} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      error_cnt = 0;
      cmp_count = 0;
      cm = 0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rdc(`CTM_ADDR_CTL0, 32'h0);
      rdc(`CTM_ADDR_ROUTE_A, 32'hb3);
      rdc(`CTM_ADDR_ROUTE_B, 32'h33);
      cnt(0);
      xfer(1'b1, `CTM_ADDR_ROUTE_A, 32'hffffffff);
      xfer(1'b1, `CTM_ADDR_ROUTE_B, 32'hffffffff);
      rdc(`CTM_ADDR_ROUTE_A, 32'hf3);
      rdc(`CTM_ADDR_ROUTE_B, 32'h33);
      chk({ra, rb}, 16'hf333);
      xfer(1'b0, 12'h020, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      v = xs();
      xfer(1'b1, `CTM_ADDR_CTL1, v & 32'hff);
      rdc(`CTM_ADDR_CTL1, v & 32'hff);
      for (int i = 0; i < 4; i++) begin
         v = xs();
         if (i == 3) v = 32'h1000 | (16 + v[5:0]);
         xfer(1'b1, `CTM_ADDR_CMPA_LO, v & 32'hff);
         rdc(`CTM_ADDR_CMPA_HI, cm >> 8);
         rdc(`CTM_ADDR_CMPA_LO, cm & 255);
         xfer(1'b1, `CTM_ADDR_CMPA_LO, v & 32'hff);
         xfer(1'b1, `CTM_ADDR_CMPA_HI, (v >> 8) & 32'hff);
         cm = v[9:0];
         rdc(`CTM_ADDR_CMPA_HI, cm >> 8);
         rdc(`CTM_ADDR_CMPA_LO, cm & 255);
      end
      xfer(1'b1, `CTM_ADDR_CTL0, 32'h58);
      repeat (20) @(posedge sys_clk);
      cnt(0);
      xfer(1'b1, `CTM_ADDR_CTL0, 32'h0);
      xfer(1'b1, `CTM_ADDR_CTL1, 32'h01);
      xfer(1'b1, `CTM_ADDR_CTL0, 32'h18);
      gap(1'b0, cm + 1);
      xfer(1'b0, `CTM_ADDR_CNT_HI, 32'h0);
      v = rd;
      xfer(1'b0, `CTM_ADDR_CNT_LO, 32'h0);
      chk(((v & 3) << 8 | rd) <= cm, 1);
      xfer(1'b1, `CTM_ADDR_CTL0, 32'h0);
      xfer(1'b1, `CTM_ADDR_CTL1, 32'h0);
      xfer(1'b1, `CTM_ADDR_CTL0, 32'h19);
      gap(1'b1, 129);
      for (int k = 6; k < 8; k++) begin
         xfer(1'b1, `CTM_ADDR_CTL0, 32'h0);
         xfer(1'b1, `CTM_ADDR_CTL0, (k << 4) | 32'h0f);
         pulses(5);
         cnt(5);
         xfer(1'b1, `CTM_ADDR_CTL0, (k << 4) | 32'h8f);
         pulses(3);
         cnt(5);
      end
      xfer(1'b1, `CTM_ADDR_CTL0, 32'h08);
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, `CTM_ADDR_CTL1, 32'hc8 | (k << 1));
         repeat (4) @(negedge sys_clk);
         chk({p1, p0}, {k == 0, 1'b1});
      end
      // PWM at one tick per four clocks: high for compare-A ticks of every 1024.
      xfer(1'b1, `CTM_ADDR_CTL1, 32'h88);
      repeat (8) @(negedge sys_clk);
      n = 0;
      repeat (4096) begin
         @(negedge sys_clk);
         n += (p0 === 1'b1);
      end
      chk(n, 4 * cm);
      xfer(1'b1, `CTM_ADDR_ROUTE_A, 32'h0);
      repeat (4) @(negedge sys_clk);
      chk({p1, p0}, 32'h0);
      summarize();
   end
endmodule // testbench
`default_nettype wire
